// ### rtl/fsw_pkg.sv
/*
 * fsw_pkg: constants, register map and types of the frequency control
 * block (shift keying, linear sweep, external frequency deviation).
 * Assumes a single 100 MHz clock; all frequencies are whole hertz,
 * the shift rate is in millihertz.
 */
package fsw_pkg;

    localparam logic [31:0] CLK_HZ         = 32'h05F5_E100;
    // rate accumulator wraps at one second expressed in mHz-cycles
    localparam logic [39:0] RATE_WRAP      = 40'h17_4876_E800;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CARRIER = 8'h04;
    localparam logic [7:0] OFS_HOP     = 8'h08;
    localparam logic [7:0] OFS_RATE    = 8'h0C;
    localparam logic [7:0] OFS_START   = 8'h10;
    localparam logic [7:0] OFS_STOP    = 8'h14;
    localparam logic [7:0] OFS_CENTER  = 8'h18;
    localparam logic [7:0] OFS_SPAN    = 8'h1C;
    localparam logic [7:0] OFS_MARKER  = 8'h20;
    localparam logic [7:0] OFS_SWTIME  = 8'h24;
    localparam logic [7:0] OFS_FMDEV   = 8'h28;
    localparam logic [7:0] OFS_STATUS  = 8'h2C;

    // frequency limits per carrier shape, hertz
    localparam logic [31:0] FMAX_FULL  = 32'h04C4_B400;
    localparam logic [31:0] FMAX_RAMP  = 32'h000F_4240;
    localparam logic [31:0] FMAX_ARB   = 32'h017D_7840;

    // values after reset
    localparam logic [31:0] RST_CARRIER = 32'h0000_03E8;
    localparam logic [31:0] RST_HOP     = 32'h0000_0064;
    localparam logic [31:0] RST_RATE    = 32'h0000_2710;
    localparam logic [31:0] RST_START   = 32'h0000_0064;
    localparam logic [31:0] RST_STOP    = 32'h0000_03E8;
    localparam logic [31:0] RST_MARKER  = 32'h0000_01F4;
    localparam logic [31:0] RST_FMDEV   = 32'h0000_0064;
    localparam logic [31:0] SWEEP_TIME_S = 32'h0000_0001;

    // shift rate bounds, millihertz
    localparam logic [31:0] RATE_MIN   = 32'h0000_0002;
    localparam logic [31:0] RATE_MAX   = 32'h05F5_E100;

    // sweep is cut into 2^SWEEP_LOG2 equal steps
    localparam int unsigned SWEEP_LOG2 = 10;
    localparam logic [10:0] SWEEP_LAST = 11'h400;
    localparam logic [10:0] SWEEP_MID  = 11'h200;

    typedef enum logic [2:0] {
        FSW_MODE_OFF, FSW_MODE_AM, FSW_MODE_FM, FSW_MODE_FSK,
        FSW_MODE_SWEEP, FSW_MODE_BURST
    } fsw_mode_t;

    typedef enum logic [2:0] {
        FSW_SHP_SINE, FSW_SHP_SQUARE, FSW_SHP_RAMP, FSW_SHP_ARB,
        FSW_SHP_PULSE, FSW_SHP_NOISE, FSW_SHP_DC
    } fsw_shape_t;

    // control register layout, low bits of the word
    typedef struct packed {
        logic       fmExt;
        logic       markerEn;
        logic       fskExt;
        fsw_shape_t shape;
        fsw_mode_t  mode;
    } fsw_ctrl_t;

    localparam fsw_ctrl_t RST_CTRL = '{fmExt: 1'b0, markerEn: 1'b0,
        fskExt: 1'b0, shape: FSW_SHP_SINE, mode: FSW_MODE_OFF};

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fsw_req_t;

endpackage

// ### rtl/fsw_freq_ctrl.sv
/*
 * fsw_freq_ctrl: selects the output frequency word of the generator:
 * plain carrier, shift keying between carrier and hop frequency,
 * linear phase-continuous sweep with sync output, and carrier plus an
 * externally scaled deviation. Registers sit on a plain strobe port.
 * Assumes trigIn and modIn are synchronous-ish levels, the downstream
 * synthesizer keeps phase when its frequency word changes.
 */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module fsw_freq_ctrl #(
    parameter logic [31:0] SWEEP_TIME_RST = 32'h05F5_E100
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        trigIn,
    input  wire logic [11:0] modIn,
    output logic      [31:0] outFreq,
    output logic             syncOut,
    output logic             hopActive
);

    fsw_pkg::fsw_ctrl_t ctrl;
    fsw_pkg::fsw_req_t  req;
    logic [31:0] carrier;
    logic [31:0] hop;
    logic [31:0] shiftRate;
    logic [31:0] startFreq;
    logic [31:0] stopFreq;
    logic [31:0] marker;
    logic [31:0] sweepTime;
    logic [31:0] fmDev;
    logic        trigMeta;
    logic        trigSync;
    logic [39:0] rateAcc;
    logic        intSquare;
    logic [31:0] stepCnt;
    logic [10:0] pointIdx;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // frequency cap of the present shape
    function automatic logic [31:0] capOf(input fsw_pkg::fsw_shape_t s);
        logic [31:0] c;
        c = fsw_pkg::FMAX_FULL;
        if (s == fsw_pkg::FSW_SHP_RAMP) begin
            c = fsw_pkg::FMAX_RAMP;
        end else if (s == fsw_pkg::FSW_SHP_ARB) begin
            c = fsw_pkg::FMAX_ARB;
        end
        return c;
    endfunction

    // clip a signed value into 0..cap
    function automatic logic [31:0] clip(input logic signed [34:0] v,
                                         input logic [31:0] cap);
        logic [31:0] r;
        r = v[31:0];
        if (v < 35'sd0) begin
            r = 32'h0000_0000;
        end else if (v > $signed({3'b000, cap})) begin
            r = cap;
        end
        return r;
    endfunction

    wire logic [31:0] capNow = capOf(ctrl.shape);
    wire logic signed [34:0] wrVal = $signed({3'b000, req.wdata});

    // sweep limits, also viewed as center and span
    wire logic signed [34:0] startS = $signed({3'b000, startFreq});
    wire logic signed [34:0] stopS  = $signed({3'b000, stopFreq});
    wire logic signed [34:0] spanS  = stopS - startS;
    wire logic signed [34:0] centerS = (startS + stopS) >>> 1;
    wire logic signed [34:0] wrSpan = {{3{req.wdata[31]}}, req.wdata};
    // center write keeps span, span write keeps center
    wire logic signed [34:0] cenStart = wrVal - (spanS >>> 1);
    wire logic signed [34:0] cenStop  = cenStart + spanS;
    wire logic signed [34:0] spnStart = centerS - (wrSpan >>> 1);
    wire logic signed [34:0] spnStop  = spnStart + wrSpan;

    // control write: reject non-carrier shapes while keying
    wire fsw_pkg::fsw_ctrl_t wrCtrl = fsw_pkg::fsw_ctrl_t'(req.wdata[8:0]);
    wire logic badShape = (wrCtrl.shape == fsw_pkg::FSW_SHP_PULSE)
                        || (wrCtrl.shape == fsw_pkg::FSW_SHP_NOISE)
                        || (wrCtrl.shape == fsw_pkg::FSW_SHP_DC)
                        || (wrCtrl.shape > fsw_pkg::FSW_SHP_DC);
    wire logic keyWr = wrCtrl.mode == fsw_pkg::FSW_MODE_FSK;
    wire logic modeOk = wrCtrl.mode <= fsw_pkg::FSW_MODE_BURST;
    wire logic ctrlOk = modeOk && !(keyWr && badShape);

    wire logic [31:0] rateClip =
        (req.wdata < fsw_pkg::RATE_MIN) ? fsw_pkg::RATE_MIN :
        (req.wdata > fsw_pkg::RATE_MAX) ? fsw_pkg::RATE_MAX :
        req.wdata;

    wire logic wrCtrlHit   = req.wr && req.addr == fsw_pkg::OFS_CTRL;
    wire logic wrCarrier   = req.wr && req.addr == fsw_pkg::OFS_CARRIER;
    wire logic wrHop       = req.wr && req.addr == fsw_pkg::OFS_HOP;
    wire logic wrRate      = req.wr && req.addr == fsw_pkg::OFS_RATE;
    wire logic wrStart     = req.wr && req.addr == fsw_pkg::OFS_START;
    wire logic wrStop      = req.wr && req.addr == fsw_pkg::OFS_STOP;
    wire logic wrCenter    = req.wr && req.addr == fsw_pkg::OFS_CENTER;
    wire logic wrSpanHit   = req.wr && req.addr == fsw_pkg::OFS_SPAN;
    wire logic wrMarker    = req.wr && req.addr == fsw_pkg::OFS_MARKER;
    wire logic wrSwTime    = req.wr && req.addr == fsw_pkg::OFS_SWTIME;
    wire logic wrFmDev     = req.wr && req.addr == fsw_pkg::OFS_FMDEV;

    // one mode field: selecting any mode replaces the previous one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= fsw_pkg::RST_CTRL;
        end else if (wrCtrlHit && ctrlOk) begin
            ctrl <= wrCtrl;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            carrier <= fsw_pkg::RST_CARRIER;
            hop     <= fsw_pkg::RST_HOP;
        end else if (wrCarrier) begin
            carrier <= clip(wrVal, capNow);
        end else if (wrHop) begin
            hop <= clip(wrVal, capNow);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shiftRate <= fsw_pkg::RST_RATE;
            marker    <= fsw_pkg::RST_MARKER;
            sweepTime <= SWEEP_TIME_RST;
            fmDev     <= fsw_pkg::RST_FMDEV;
        end else begin
            if (wrRate) begin
                shiftRate <= rateClip;
            end
            if (wrMarker) begin
                marker <= clip(wrVal, capNow);
            end
            if (wrSwTime) begin
                sweepTime <= req.wdata;
            end
            if (wrFmDev) begin
                fmDev <= req.wdata;
            end
        end
    end

    // sweep endpoints; center and span writes move both at once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startFreq <= fsw_pkg::RST_START;
            stopFreq  <= fsw_pkg::RST_STOP;
        end else if (wrStart) begin
            startFreq <= clip(wrVal, capNow);
        end else if (wrStop) begin
            stopFreq <= clip(wrVal, capNow);
        end else if (wrCenter) begin
            startFreq <= clip(cenStart, capNow);
            stopFreq  <= clip(cenStop, capNow);
        end else if (wrSpanHit) begin
            startFreq <= clip(spnStart, capNow);
            stopFreq  <= clip(spnStop, capNow);
        end
    end

    // two-stage synchroniser; only trigSync is looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trigMeta <= 1'b0;
            trigSync <= 1'b0;
        end else begin
            trigMeta <= trigIn;
            trigSync <= trigMeta;
        end
    end

    // internal keying: toggle twice per rate period, equal halves
    wire logic [39:0] rateStep = {7'h00, shiftRate, 1'b0};
    wire logic [39:0] rateSum  = rateAcc + rateStep;
    wire logic        rateWrap = rateSum >= fsw_pkg::RATE_WRAP;
    wire logic        keyRun   = ctrl.mode == fsw_pkg::FSW_MODE_FSK;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rateAcc   <= 40'h00_0000_0000;
            intSquare <= 1'b0;
        end else if (!keyRun || ctrl.fskExt) begin
            rateAcc   <= 40'h00_0000_0000;
            intSquare <= 1'b0;
        end else if (rateWrap) begin
            rateAcc   <= rateSum - fsw_pkg::RATE_WRAP;
            intSquare <= !intSquare;
        end else begin
            rateAcc <= rateSum;
        end
    end

    // external level used straight, high selects hop
    wire logic selHop = ctrl.fskExt ? trigSync : intSquare;

    // sweep: fixed number of equal steps across the programmed time
    wire logic [31:0] stepLen0 = sweepTime >> fsw_pkg::SWEEP_LOG2;
    wire logic [31:0] stepLen  = (stepLen0 == 32'h0000_0000)
                               ? 32'h0000_0001 : stepLen0;
    wire logic sweepRun = ctrl.mode == fsw_pkg::FSW_MODE_SWEEP;
    wire logic stepDone = stepCnt >= stepLen - 32'h0000_0001;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stepCnt  <= 32'h0000_0000;
            pointIdx <= 11'h000;
        end else if (!sweepRun) begin
            stepCnt  <= 32'h0000_0000;
            pointIdx <= 11'h000;
        end else if (stepDone) begin
            stepCnt  <= 32'h0000_0000;
            // after the stop point the sweep restarts at start
            pointIdx <= (pointIdx == fsw_pkg::SWEEP_LAST)
                      ? 11'h000 : pointIdx + 11'h001;
        end else begin
            stepCnt <= stepCnt + 32'h0000_0001;
        end
    end

    // signed span gives direction: start below stop rises
    wire logic signed [46:0] spanProd =
        spanS * $signed({1'b0, pointIdx});
    wire logic signed [34:0] sweepOfs =
        35'(spanProd >>> fsw_pkg::SWEEP_LOG2);
    wire logic signed [34:0] sweepS = startS + sweepOfs;
    wire logic [31:0] sweepFreq = sweepS[31:0];
    wire logic sweepUp = stopFreq >= startFreq;
    wire logic markReached = sweepUp ? (sweepFreq >= marker)
                                     : (sweepFreq <= marker);
    wire logic atStart = pointIdx == 11'h000;
    wire logic next_sync = !sweepRun ? 1'b0
                         : atStart ? 1'b1
                         : ctrl.markerEn ? !markReached
                         : (pointIdx < fsw_pkg::SWEEP_MID);

    // external fm: deviation times signed level, full scale 2048
    wire logic signed [44:0] devProd =
        $signed({1'b0, fmDev}) * $signed(modIn);
    wire logic signed [34:0] devOfs = 35'(devProd >>> 11);
    wire logic signed [34:0] fmS = $signed({3'b000, carrier}) + devOfs;

    wire logic fmExtRun = ctrl.mode == fsw_pkg::FSW_MODE_FM && ctrl.fmExt;
    wire logic next_hop = keyRun && selHop;
    // no extra cap on sweep points: they lie between clipped endpoints
    wire logic [31:0] next_freq =
        sweepRun ? sweepFreq
      : next_hop ? hop
      : fmExtRun ? clip(fmS, capNow)
      : carrier;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outFreq   <= fsw_pkg::RST_CARRIER;
            syncOut   <= 1'b0;
            hopActive <= 1'b0;
        end else begin
            outFreq   <= next_freq;
            syncOut   <= next_sync;
            hopActive <= next_hop;
        end
    end

    // read mux; status shows live output state
    wire logic [31:0] statusWord = {18'h0_0000, pointIdx,
                                    intSquare, trigSync, hopActive};
    wire logic [31:0] spanWord = spanS[31:0];
    wire logic [31:0] centerWord = centerS[31:0];
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (req.addr)
            fsw_pkg::OFS_CTRL:    next_rdata = {23'h00_0000, ctrl};
            fsw_pkg::OFS_CARRIER: next_rdata = carrier;
            fsw_pkg::OFS_HOP:     next_rdata = hop;
            fsw_pkg::OFS_RATE:    next_rdata = shiftRate;
            fsw_pkg::OFS_START:   next_rdata = startFreq;
            fsw_pkg::OFS_STOP:    next_rdata = stopFreq;
            fsw_pkg::OFS_CENTER:  next_rdata = centerWord;
            fsw_pkg::OFS_SPAN:    next_rdata = spanWord;
            fsw_pkg::OFS_MARKER:  next_rdata = marker;
            fsw_pkg::OFS_SWTIME:  next_rdata = sweepTime;
            fsw_pkg::OFS_FMDEV:   next_rdata = fmDev;
            fsw_pkg::OFS_STATUS:  next_rdata = statusWord;
            default:              next_rdata = 32'h0000_0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 32'h0000_0000;
        end else if (req.rd) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

endmodule // fsw_freq_ctrl

// ### dv/fsw_freq_ctrl_asserts.sv
/*
 * fsw_freq_ctrl_asserts: port-level checks of keying and sweep sync.
 * Assumes only the top module's ports; mode is tracked from CTRL writes.
 */
`timescale 1ns/1ps
module fsw_freq_ctrl_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        trigIn,
    input wire logic [11:0] modIn,
    input wire logic [31:0] outFreq,
    input wire logic        syncOut,
    input wire logic        hopActive
);
    localparam int CW = $bits(fsw_pkg::fsw_ctrl_t);
    fsw_pkg::fsw_ctrl_t ctrlQ;
    fsw_pkg::fsw_ctrl_t wCtrl;
    logic               ctrlOk;
    logic               fskQ;
    logic               fskXq;
    logic               sweepQ;

    // refused writes leave the mode as it was
    assign wCtrl  = fsw_pkg::fsw_ctrl_t'(regWdata[CW-1:0]);
    assign ctrlOk = regWr && regAddr == fsw_pkg::OFS_CTRL
        && wCtrl.mode <= fsw_pkg::FSW_MODE_BURST
        && !(wCtrl.mode == fsw_pkg::FSW_MODE_FSK
             && wCtrl.shape > fsw_pkg::FSW_SHP_ARB);
    assign fskQ   = ctrlQ.mode == fsw_pkg::FSW_MODE_FSK;
    assign fskXq  = fskQ && ctrlQ.fskExt;
    assign sweepQ = ctrlQ.mode == fsw_pkg::FSW_MODE_SWEEP;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) ctrlQ <= fsw_pkg::RST_CTRL;
        else if (ctrlOk) ctrlQ <= wCtrl;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_trig_hop_hi: assert property (
        (fskXq && trigIn)[*3] |=> hopActive)
        else $error("hop not selected while trigger high");
    chk_trig_hop_lo: assert property (
        (fskXq && !trigIn)[*3] |=> !hopActive)
        else $error("hop selected while trigger low");
    chk_trig_sync_delay: assert property (
        (fskXq && !trigIn)[*4] ##1 (fskXq && trigIn)[*4]
        |-> !$past(hopActive, 3) && hopActive)
        else $error("trigger not passed through two stages");
    chk_hop_fsk_only: assert property (
        !fskQ[*3] |-> !hopActive)
        else $error("hop flag outside keying mode");
    chk_sync_idle: assert property (
        !sweepQ ##1 !sweepQ |-> !syncOut)
        else $error("sync high outside sweep");
    chk_sync_start: assert property (
        $rose(sweepQ) |=> syncOut)
        else $error("sync not high at sweep start");
    chk_sync_rise_sweep: assert property (
        $rose(syncOut) |-> sweepQ && $past(sweepQ))
        else $error("sync rose without a running sweep");
    chk_ext_freq_steady: assert property (
        (fskXq && !regWr && $stable(trigIn))[*4] |=> $stable(outFreq))
        else $error("frequency moved with steady trigger");
endmodule // fsw_freq_ctrl_asserts

bind fsw_freq_ctrl fsw_freq_ctrl_asserts u_chk (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigIn(trigIn),
    .modIn(modIn), .outFreq(outFreq), .syncOut(syncOut),
    .hopActive(hopActive)
);

// ### dv/fsw_trig_src.sv
/*
 * fsw_trig_src: outside keying controller and sync consumer.
 * Assumes the bench asks for a level; the model paces the toggles.
 */
`timescale 1ns/1ps
module fsw_trig_src (
    input wire logic   clk,
    input wire logic   nrst,
    input wire logic   wantHigh,
    input wire logic   syncOut,
    output logic       trigIn,
    output logic [15:0] syncRises
);
    logic [7:0] gap;
    logic       syncQ;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trigIn    <= 1'b0;
            gap       <= 8'h00;
            syncQ     <= 1'b0;
            syncRises <= 16'h0000;
        end else begin
            syncQ <= syncOut;
            if (syncOut && !syncQ) syncRises <= syncRises + 16'h0001;
            if (wantHigh != trigIn && gap >= 8'h64) begin
                trigIn <= wantHigh;
                gap    <= 8'h00;
            end else if (gap != 8'hFF) begin
                gap <= gap + 8'h01;
            end
        end
    end
endmodule // fsw_trig_src

// ### dv/fsw_freq_ctrl_bench.sv
/*
 * fsw_freq_ctrl_bench: scenario tasks for keying, sweep and fm.
 * Assumes the checker is bound in and sweep time is shortened.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin \
    mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module fsw_freq_ctrl_bench;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        want = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic [11:0] modIn = 12'h000;
    logic [31:0] regRdata;
    logic [31:0] outFreq;
    logic        syncOut;
    logic        hopActive;
    logic        trigIn;
    logic [15:0] rises;
    int          mismatches = 0;
    int          numChecks = 0;

    always #5 clk = ~clk;

    fsw_freq_ctrl #(.SWEEP_TIME_RST(32'h0000_0800)) dut (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .trigIn(trigIn), .modIn(modIn), .outFreq(outFreq),
        .syncOut(syncOut), .hopActive(hopActive));
    fsw_trig_src partner (.clk(clk), .nrst(nrst), .wantHigh(want),
        .syncOut(syncOut), .trigIn(trigIn), .syncRises(rises));

    function automatic logic [31:0] ctl(input int m, input int s,
                                        input logic fx, input logic mk,
                                        input logic fm);
        fsw_pkg::fsw_ctrl_t c;
        c = '{fmExt: fm, markerEn: mk, fskExt: fx,
              shape: fsw_pkg::fsw_shape_t'(s),
              mode: fsw_pkg::fsw_mode_t'(m)};
        return 32'(c);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
                         input string n);
        @(posedge clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 `CHK(n, e, regRdata)
    endtask

    // bounded wait, then compare: latency differs per path
    task automatic waitFreq(input logic [31:0] e);
        #1;
        for (int i = 0; i < 300 && outFreq !== e; i++) @(posedge clk) #1;
        `CHK("outFreq", e, outFreq)
    endtask

    task automatic t_reset;
        #1 `CHK("outFreq", fsw_pkg::RST_CARRIER, outFreq)
        rdChk(fsw_pkg::OFS_CARRIER, fsw_pkg::RST_CARRIER, "car");
        rdChk(fsw_pkg::OFS_HOP, fsw_pkg::RST_HOP, "hop");
        rdChk(fsw_pkg::OFS_RATE, fsw_pkg::RST_RATE, "rate");
        rdChk(fsw_pkg::OFS_START, fsw_pkg::RST_START, "start");
        rdChk(fsw_pkg::OFS_STOP, fsw_pkg::RST_STOP, "stop");
        rdChk(fsw_pkg::OFS_CENTER, 32'h0000_0226, "center");
        rdChk(fsw_pkg::OFS_SPAN, 32'h0000_0384, "span");
        rdChk(fsw_pkg::OFS_CTRL, 32'(fsw_pkg::RST_CTRL), "ctrl");
        rdChk(8'h30, 32'h0, "unmapped");
    endtask

    task automatic t_clip;
        int sh[4] = '{2, 3, 0, 2};
        logic [7:0] ad[4] = '{fsw_pkg::OFS_CARRIER, fsw_pkg::OFS_HOP,
                              fsw_pkg::OFS_CARRIER, fsw_pkg::OFS_START};
        logic [31:0] dt[4] = '{32'h001E_8480, 32'h01C9_C380,
                               32'h055D_4A80, 32'h001E_8480};
        logic [31:0] ex[4] = '{fsw_pkg::FMAX_RAMP, fsw_pkg::FMAX_ARB,
                               fsw_pkg::FMAX_FULL, fsw_pkg::FMAX_RAMP};
        for (int i = 0; i < 4; i++) begin
            wr(fsw_pkg::OFS_CTRL, ctl(0, sh[i], 0, 0, 0));
            wr(ad[i], dt[i]);
            rdChk(ad[i], ex[i], "capped");
        end
    endtask

    task automatic t_modes;
        logic [31:0] last;
        for (int m = 0; m < 6; m++) begin
            wr(fsw_pkg::OFS_CTRL, ctl(m, 0, 0, 0, 0));
            rdChk(fsw_pkg::OFS_CTRL, ctl(m, 0, 0, 0, 0), "mode");
        end
        for (int s = 0; s < 7; s++) begin
            if (s < 4) last = ctl(3, s, 0, 0, 0);
            wr(fsw_pkg::OFS_CTRL, ctl(3, s, 0, 0, 0));
            rdChk(fsw_pkg::OFS_CTRL, last, "shape");
        end
        wr(fsw_pkg::OFS_CTRL, ctl(4, 0, 0, 0, 0));
        wr(fsw_pkg::OFS_CTRL, ctl(3, 0, 0, 0, 0));
        repeat (2) @(posedge clk);
        #1 `CHK("syncOut", 1'b0, syncOut)
    endtask

    task automatic t_fsk_ext;
        wr(fsw_pkg::OFS_CARRIER, 32'h0000_1388);
        wr(fsw_pkg::OFS_HOP, 32'h0000_1B58);
        wr(fsw_pkg::OFS_RATE, fsw_pkg::RATE_MAX);
        wr(fsw_pkg::OFS_CTRL, ctl(3, 0, 1, 0, 0));
        waitFreq(32'h0000_1388);
        want <= 1'b1;
        waitFreq(32'h0000_1B58);
        `CHK("hopActive", 1'b1, hopActive)
        // longer than one internal half period at the top rate
        repeat (600) @(posedge clk);
        #1 `CHK("outFreq", 32'h0000_1B58, outFreq)
        want <= 1'b0;
        waitFreq(32'h0000_1388);
    endtask

    task automatic t_fsk_int;
        int hi = 0;
        int lo = 0;
        want <= 1'b1;
        wr(fsw_pkg::OFS_CTRL, ctl(3, 0, 0, 0, 0));
        for (int i = 0; i < 2000 && hopActive !== 1'b1; i++) @(posedge clk) #1;
        `CHK("hopFreq", 32'h0000_1B58, outFreq)
        while (hopActive === 1'b1 && hi < 2000) begin @(posedge clk) #1; hi++; end
        while (hopActive === 1'b0 && lo < 2000) begin @(posedge clk) #1; lo++; end
        `CHK("halves", hi, lo)
        `CHK("halfLen", 1'b1, hi >= 499 && hi <= 501)
    endtask

    task automatic sweepRun(input logic [31:0] s, e, fall);
        int t = 0;
        int bad = 0;
        logic [31:0] prev;
        logic [15:0] r0;
        while (syncOut !== 1'b1 && t < 9000) begin @(posedge clk) #1; t++; end
        `CHK("sweepStart", s, outFreq)
        r0 = rises;
        while (syncOut === 1'b1 && t < 20000) begin @(posedge clk) #1; t++; end
        `CHK("syncFall", fall, outFreq)
        prev = outFreq;
        while (syncOut === 1'b0 && t < 20000) begin
            @(posedge clk) #1;
            t++;
            if (syncOut === 1'b0) begin
                if ((s < e) ? (outFreq < prev) : (outFreq > prev)) bad++;
                prev = outFreq;
            end
        end
        `CHK("endpoint", e, prev)
        `CHK("order", 0, bad)
        `CHK("restart", s, outFreq)
        `CHK("syncRises", r0 + 16'h0001, rises)
    endtask

    task automatic t_sweep;
        wr(fsw_pkg::OFS_CTRL, ctl(0, 0, 0, 0, 0));
        wr(fsw_pkg::OFS_START, 32'h0000_03E8);
        wr(fsw_pkg::OFS_STOP, 32'h0000_07E8);
        wr(fsw_pkg::OFS_SWTIME, 32'h0000_1000);
        rdChk(fsw_pkg::OFS_CENTER, 32'h0000_05E8, "center");
        rdChk(fsw_pkg::OFS_SPAN, 32'h0000_0400, "span");
        wr(fsw_pkg::OFS_CTRL, ctl(4, 0, 0, 0, 0));
        sweepRun(32'h0000_03E8, 32'h0000_07E8, 32'h0000_05E8);
        wr(fsw_pkg::OFS_CTRL, ctl(0, 0, 0, 0, 0));
        wr(fsw_pkg::OFS_SPAN, 32'hFFFF_FC00);
        rdChk(fsw_pkg::OFS_START, 32'h0000_07E8, "start");
        rdChk(fsw_pkg::OFS_STOP, 32'h0000_03E8, "stop");
        wr(fsw_pkg::OFS_MARKER, 32'h0000_0708);
        wr(fsw_pkg::OFS_CTRL, ctl(4, 0, 0, 1, 0));
        sweepRun(32'h0000_07E8, 32'h0000_03E8, 32'h0000_0708);
    endtask

    task automatic t_fm;
        wr(fsw_pkg::OFS_CARRIER, 32'h0000_2710);
        wr(fsw_pkg::OFS_FMDEV, 32'h0000_0800);
        wr(fsw_pkg::OFS_CTRL, ctl(2, 0, 0, 0, 1));
        modIn <= 12'h400;
        waitFreq(32'h0000_2B10);
        @(posedge clk);
        modIn <= 12'h800;
        waitFreq(32'h0000_1F10);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_clip();
        t_modes();
        t_fsk_ext();
        t_fsk_int();
        t_sweep();
        t_fm();
        conclude();
    end

    // sweeps dominate: two of about 4100 cycles each
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule // fsw_freq_ctrl_bench
